// ### core/tec_map.svh
// Purpose: constants of the timer/event counter with tone output
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   offsets, field positions, reset values and timing counts
// How it works
// R1 - 8-bit up counter, pin or internal clock
// R2 - control bits 7:6 select counting mode
// R3 - prescaler divides system clock by 2^field
// R4 - count to FFH, then reload preload
// R5 - overflow sets flag bit 5 with reload
// R6 - value write hits preload, read live count
// R7 - write loads counter too while stopped
// R8 - counting clock blocked during value reads
// R9 - counting only while run bit set
// R10 - pulse mode clears run; others software only
// R11 - edge bit picks rising or falling pin edge
// R12 - pulse mode measures one pulse then holds
// R13 - pulse measurement starts on edges, not levels
// R14 - pulse mode overflow reloads and flags too
// R15 - internal base: system or slow oscillator clock
// R16 - overflow is a wake-up source
// R17 - enable bit gates interrupt, flag still set
// R18 - tone toggles on every overflow
// R19 - shared pin: tone when latch 1, else low
// R20 - control bit 5 reads zero
// R21 - mode 00 never counts nor overflows
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH
`define TEC_IDX_VALUE    8'h0d
`define TEC_IDX_CTRL     8'h0e
`define TEC_IDX_IRQ      8'h10
`define TEC_IDX_PIN      8'h11
`define TEC_CTRL_MODE_HI 7
`define TEC_CTRL_MODE_LO 6
`define TEC_CTRL_RSVD    5
`define TEC_CTRL_RUN     4
`define TEC_CTRL_EDGE    3
`define TEC_CTRL_PSC_HI  2
`define TEC_IRQ_FLAG     5
`define TEC_IRQ_EN       2
`define TEC_PIN_LATCH    0
`define TEC_PIN_OUTMODE  1
`define TEC_CTRL_RST     8'h08
`define TEC_CNT_RST      8'h00
`define TEC_CNT_MAX      8'hff
`define TEC_PSC_PERIOD_NS 10
`endif

// ### core/tec_pkg.sv
// Purpose: types of the timer/event counter
// Assumes: constants live in tec_map.svh
// Notes:   whole-module state is one packed struct
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_MODE_NONE  = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_t;
  typedef enum logic [1:0] {
    TEC_PW_WAIT = 2'b00,
    TEC_PW_MEAS = 2'b01,
    TEC_PW_DONE = 2'b11
  } tec_pw_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] preload;
    tec_mode_t  mode;
    logic       run;
    logic       edge_fall;
    logic [2:0] psc;
    logic       tf;
    logic       overflow_irq_enable;
    logic       latch;
    logic       outmode;
    logic       tone;
    logic [6:0] pre;
    logic       pin_prev;
    logic       rtc_prev;
    tec_pw_t    pw;
    logic       wake;
    logic [31:0] prdata;
  } tec_state_t;
endpackage : tec_pkg

// ### core/tec_top.sv
// Purpose: 8-bit timer/event counter with tone output, APB slave
// Assumes: count pin and slow oscillator are synchronous to clk_sys_i
// Notes:   reads of the value register stall counting for the transfer
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "tec_map.svh"
module tec_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              count_value_or_input_i,
  input  wire logic              slow_osc_clock_i,
  input  wire logic              rtc_option_i,
  input  wire logic              rtc_osc_present_i,
  input  wire logic              tone_option_i,
  output logic                   tone_shared_pin_o,
  output logic                   tone_shared_pin_oe_o,
  output logic                   overflow_irq_o,
  output logic                   wake_o
);
  localparam logic [ADDR_W-1:0] A_VALUE = ADDR_W'({`TEC_IDX_VALUE, 2'b00});
  localparam logic [ADDR_W-1:0] A_CTRL  = ADDR_W'({`TEC_IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] A_IRQ   = ADDR_W'({`TEC_IDX_IRQ, 2'b00});
  localparam logic [ADDR_W-1:0] A_PIN   = ADDR_W'({`TEC_IDX_PIN, 2'b00});

  // Prescaler compare mask: all ones in the low psc bits
  function automatic logic [6:0] psc_mask(input logic [2:0] p);
    logic [7:0] m;
    m = (8'h01 << p) - 8'h01;
    return m[6:0];
  endfunction : psc_mask

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == A_VALUE) || (a == A_CTRL) || (a == A_IRQ) || (a == A_PIN);
  endfunction : addr_hit

  tec_pkg::tec_state_t st_reg;
  tec_pkg::tec_state_t st_next;

  logic setup;
  logic access;
  logic wr;
  logic rd_block;
  logic use_rtc;
  logic base_tick;
  logic psc_tick;
  logic pin_rise;
  logic pin_fall;
  logic act_edge;
  logic ret_edge;
  logic tick;
  logic ovf;
  logic [31:0] rd_mux;

  assign setup     = psel_i && !penable_i;
  assign access    = psel_i && penable_i;
  assign wr        = access && pwrite_i;
  // Blocking over both phases of a read keeps the sampled value coherent
  assign rd_block  = psel_i && !pwrite_i && (paddr_i == A_VALUE); // [R8]
  assign use_rtc   = rtc_option_i && rtc_osc_present_i; // [R15]
  assign base_tick = use_rtc ? (slow_osc_clock_i && !st_reg.rtc_prev) : 1'b1; // [R15]
  assign psc_tick  = base_tick &&
                     ((st_reg.pre & psc_mask(st_reg.psc)) == psc_mask(st_reg.psc)); // [R3]
  assign pin_rise  = count_value_or_input_i && !st_reg.pin_prev;
  assign pin_fall  = !count_value_or_input_i && st_reg.pin_prev;
  assign act_edge  = st_reg.edge_fall ? pin_fall : pin_rise; // [R11]
  assign ret_edge  = st_reg.edge_fall ? pin_rise : pin_fall;

  always_comb begin
    tick = 1'b0;
    if (st_reg.run && !rd_block) begin // [R9] [R8]
      unique case (st_reg.mode)
        tec_pkg::TEC_MODE_EVENT: tick = act_edge; // [R1]
        tec_pkg::TEC_MODE_TIMER: tick = psc_tick;
        tec_pkg::TEC_MODE_PULSE: tick = psc_tick && (st_reg.pw == tec_pkg::TEC_PW_MEAS);
        tec_pkg::TEC_MODE_NONE:  tick = 1'b0; // [R21]
      endcase
    end
  end

  assign ovf = tick && (st_reg.cnt == `TEC_CNT_MAX); // [R4]

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      A_VALUE: rd_mux[7:0] = st_reg.cnt; // [R6]
      A_CTRL: begin
        rd_mux[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO] = st_reg.mode;
        rd_mux[`TEC_CTRL_RSVD] = 1'b0; // [R20]
        rd_mux[`TEC_CTRL_RUN]  = st_reg.run;
        rd_mux[`TEC_CTRL_EDGE] = st_reg.edge_fall;
        rd_mux[`TEC_CTRL_PSC_HI:0] = st_reg.psc;
      end
      A_IRQ: begin
        rd_mux[`TEC_IRQ_FLAG] = st_reg.tf;
        rd_mux[`TEC_IRQ_EN]   = st_reg.overflow_irq_enable;
      end
      A_PIN: begin
        rd_mux[`TEC_PIN_LATCH]   = st_reg.latch;
        rd_mux[`TEC_PIN_OUTMODE] = st_reg.outmode;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next          = st_reg;
    st_next.wake     = 1'b0;
    st_next.pin_prev = count_value_or_input_i;
    st_next.rtc_prev = slow_osc_clock_i;
    if (base_tick) begin
      st_next.pre = st_reg.pre + 7'h01;
    end
    if (setup && !pwrite_i) begin
      st_next.prdata = rd_mux;
    end
    // Pulse measurement sequencing
    if (st_reg.mode == tec_pkg::TEC_MODE_PULSE && st_reg.run) begin
      unique case (st_reg.pw)
        tec_pkg::TEC_PW_WAIT: begin
          if (act_edge) begin
            st_next.pw = tec_pkg::TEC_PW_MEAS; // [R12] [R13]
          end
        end
        tec_pkg::TEC_PW_MEAS: begin
          if (ret_edge) begin
            st_next.pw  = tec_pkg::TEC_PW_DONE;
            st_next.run = 1'b0; // [R10] [R12]
          end
        end
        tec_pkg::TEC_PW_DONE: st_next.pw = tec_pkg::TEC_PW_WAIT;
        default: st_next.pw = tec_pkg::TEC_PW_WAIT;
      endcase
    end else if (!st_reg.run) begin
      st_next.pw = (st_reg.pw == tec_pkg::TEC_PW_WAIT) ? tec_pkg::TEC_PW_WAIT
                                                       : tec_pkg::TEC_PW_DONE;
    end
    if (tick) begin
      st_next.cnt = st_reg.cnt + 8'h01; // [R1]
    end
    if (ovf) begin
      st_next.cnt  = st_reg.preload; // [R4] [R14]
      st_next.tone = !st_reg.tone; // [R18]
      st_next.wake = 1'b1; // [R16]
    end
    if (wr) begin
      unique case (paddr_i)
        A_VALUE: begin
          st_next.preload = pwdata_i[7:0]; // [R6]
          if (!st_reg.run) begin
            st_next.cnt = pwdata_i[7:0]; // [R7]
          end else if (ovf) begin
            st_next.cnt = pwdata_i[7:0];
          end
        end
        A_CTRL: begin
          st_next.mode      = tec_pkg::tec_mode_t'(pwdata_i[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO]);
          st_next.run       = pwdata_i[`TEC_CTRL_RUN]; // [R9]
          st_next.edge_fall = pwdata_i[`TEC_CTRL_EDGE];
          st_next.psc       = pwdata_i[`TEC_CTRL_PSC_HI:0]; // [R2] [R3]
          if (pwdata_i[`TEC_CTRL_RUN] && !st_reg.run) begin
            st_next.pw = tec_pkg::TEC_PW_WAIT; // [R12]
          end
        end
        A_IRQ: begin
          st_next.tf  = pwdata_i[`TEC_IRQ_FLAG];
          st_next.overflow_irq_enable = pwdata_i[`TEC_IRQ_EN]; // [R17]
        end
        A_PIN: begin
          st_next.latch   = pwdata_i[`TEC_PIN_LATCH];
          st_next.outmode = pwdata_i[`TEC_PIN_OUTMODE];
        end
        default: st_next.tf = st_next.tf;
      endcase
    end
    // A flag set by hardware wins over a software clear in the same cycle
    if (ovf) begin
      st_next.tf = 1'b1; // [R5] [R17]
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg           <= '0;
      st_reg.cnt       <= `TEC_CNT_RST;
      st_reg.preload   <= `TEC_CNT_RST;
      st_reg.mode      <= tec_pkg::TEC_MODE_NONE;
      st_reg.edge_fall <= 1'b1;
      st_reg.pw        <= tec_pkg::TEC_PW_WAIT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !addr_hit(paddr_i);
  assign prdata_o  = st_reg.prdata;
  assign overflow_irq_o = st_reg.tf && st_reg.overflow_irq_enable; // [R17]
  assign wake_o = st_reg.wake; // [R16]
  // Input mode leaves the pin undriven; tone only when the option is fitted
  assign tone_shared_pin_oe_o = st_reg.outmode; // [R19]
  assign tone_shared_pin_o = tone_option_i ? (st_reg.latch && st_reg.tone)
                                           : st_reg.latch; // [R19]

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_reload;
    ovf && !(wr && paddr_i == A_VALUE) |=> st_reg.cnt == $past(st_reg.preload);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow"); // [R4]

  property p_flag;
    ovf |=> st_reg.tf && wake_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag or wake missing"); // [R5]

  property p_tone;
    ovf |=> st_reg.tone != $past(st_reg.tone);
  endproperty
  a_tone: assert property (p_tone) else $error("tone did not toggle"); // [R18]

  property p_mode_none;
    st_reg.mode == tec_pkg::TEC_MODE_NONE && !wr |=> $stable(st_reg.cnt);
  endproperty
  a_mode_none: assert property (p_mode_none) else $error("count moved in mode 00"); // [R21]

  property p_stopped;
    !st_reg.run && !wr |=> $stable(st_reg.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while off"); // [R9]

  property p_rd_block;
    rd_block |=> $stable(st_reg.cnt) || $past(wr);
  endproperty
  a_rd_block: assert property (p_rd_block) else $error("count moved during read"); // [R8]

  property p_timer_psc0;
    st_reg.mode == tec_pkg::TEC_MODE_TIMER && st_reg.run && st_reg.psc == 3'h0 &&
      !use_rtc && !rd_block && !psel_i |-> tick;
  endproperty
  a_timer_psc0: assert property (p_timer_psc0) else $error("divide-by-1 tick missing"); // [R3]

  property p_wr_stopped;
    wr && paddr_i == A_VALUE && !st_reg.run |=> st_reg.cnt == $past(pwdata_i[7:0]);
  endproperty
  a_wr_stopped: assert property (p_wr_stopped) else $error("stopped write not loaded"); // [R7]

  property p_pw_end;
    st_reg.mode == tec_pkg::TEC_MODE_PULSE && st_reg.run &&
      st_reg.pw == tec_pkg::TEC_PW_MEAS && ret_edge && !wr |=> !st_reg.run ##1 !tick;
  endproperty
  a_pw_end: assert property (p_pw_end) else $error("pulse end did not stop"); // [R10]

  property p_rsvd;
    setup && !pwrite_i && paddr_i == A_CTRL |=> !prdata_o[`TEC_CTRL_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one"); // [R20]

  property p_pin_low;
    tone_shared_pin_oe_o && !st_reg.latch |-> !tone_shared_pin_o;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not forced low"); // [R19]

  c_ovf:   cover property (ovf);
  c_event: cover property (st_reg.mode == tec_pkg::TEC_MODE_EVENT && tick);
  c_pw:    cover property (st_reg.pw == tec_pkg::TEC_PW_MEAS ##[1:50] st_reg.pw == tec_pkg::TEC_PW_DONE);
  c_err:   cover property (pslverr_o);
endmodule : tec_top

// ### tb/tec_pin_src.sv
// Purpose: far-side source of pulses on the count pin
// Assumes: pin changes just after rising clock edges
// Notes:   between bursts the pin rests at idle_i, so no stray edges
`timescale 1ns/1ps
module tec_pin_src (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic       idle_i,
  input  wire logic [7:0] pulses_i,
  input  wire logic [7:0] width_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic [8:0] left;
  logic [7:0] tmr;
  // Each level lasts width_i cycles, never less than one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left  <= 9'h000;
      tmr   <= 8'h00;
      pin_o <= 1'b0;
    end else if (start_i && left == 9'h000 && pulses_i != 8'h00) begin
      // One level fewer than twice the pulses, so the burst ends at idle
      left  <= {pulses_i, 1'b0} - 9'h001;
      tmr   <= width_i;
      pin_o <= ~idle_i;
    end else if (left == 9'h000) begin
      pin_o <= idle_i;
    end else if (tmr > 8'h01) begin
      tmr <= tmr - 8'h01;
    end else begin
      left  <= left - 9'h001;
      tmr   <= width_i;
      pin_o <= ~pin_o;
    end
  end
  assign busy_o = (left != 9'h000);
endmodule : tec_pin_src

// ### tb/timer_event_counter_tone_out_test.sv
// Purpose: self-checking bench of the timer/event counter
// Assumes: zero-wait APB slave, pin source synchronous to the clock
// Notes:   prescaled counts get a small window, reads stall the count
`timescale 1ns/1ps
`include "tec_map.svh"
module timer_event_counter_tone_out_test;
  localparam logic [7:0] A_VAL = `TEC_IDX_VALUE << 2;
  localparam logic [7:0] A_CTL = `TEC_IDX_CTRL << 2;
  localparam logic [7:0] A_IRQ = `TEC_IDX_IRQ << 2;
  localparam logic [7:0] A_PIN = `TEC_IDX_PIN << 2;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, last_err, pin, busy, pin_o, pin_oe, irq, wake;
  logic        start = 1'b0;
  logic        idle = 1'b0;
  logic        slow = 1'b0;
  logic        rtc = 1'b0;
  logic        tone_opt = 1'b1;
  logic [7:0]  pulses = 8'h00;
  logic [7:0]  width = 8'h01;
  int          n_fail = 0, n_tests = 0, cyc = 0, n_wake = 0, m_ovf = 0, m_cnt, m_pre, v;
  always #5 clk_sys_i = ~clk_sys_i;
  tec_top u_tec_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .count_value_or_input_i(pin), .slow_osc_clock_i(slow), .rtc_option_i(rtc),
    .rtc_osc_present_i(rtc), .tone_option_i(tone_opt), .tone_shared_pin_o(pin_o),
    .tone_shared_pin_oe_o(pin_oe), .overflow_irq_o(irq), .wake_o(wake));
  tec_pin_src u_tec_pin_src (.clk_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start),
    .idle_i(idle), .pulses_i(pulses), .width_i(width), .pin_o(pin), .busy_o(busy));
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task automatic pulse(input logic [7:0] p, input logic [7:0] w);
    pulses <= p;
    width  <= w;
    start  <= 1'b1;
    @(posedge clk_sys_i);
    start  <= 1'b0;
    @(posedge clk_sys_i);
    while (busy === 1'b1) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
  endtask : pulse
  // Reference counter: wraps from ff to the preload
  task automatic m_ticks(input int n);
    repeat (n) begin
      if (m_cnt == 255) begin
        m_cnt = m_pre;
        m_ovf++;
      end else m_cnt++;
    end
  endtask : m_ticks
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) n_wake++;
    if (cyc == 8000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(33609));
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rchk(A_CTL, 32'h08);
    rchk(A_VAL, 32'h00);
    apb(1'b1, A_CTL, 32'h28);
    rchk(A_CTL, 32'h08);
    apb(1'b0, 8'h3c, 32'h0);
    chk({rd[31:1], last_err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      m_pre = $urandom_range(255);
      apb(1'b1, A_VAL, m_pre);
      rchk(A_VAL, m_pre);
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, A_CTL, 32'h80 | k);
      apb(1'b1, A_VAL, 32'h0);
      apb(1'b1, A_CTL, 32'h90 | k);
      repeat (200) @(posedge clk_sys_i);
      apb(1'b1, A_CTL, 32'h80 | k);
      apb(1'b0, A_VAL, 32'h0);
      v = int'(rd[7:0]) - (203 >> k);
      chk(32'(v >= -2 && v <= 2), 32'h1);
    end
    apb(1'b1, A_VAL, 32'h0);
    rtc <= 1'b1;
    apb(1'b1, A_CTL, 32'h90);
    repeat (20) begin
      repeat (4) @(posedge clk_sys_i);
      slow <= ~slow;
    end
    repeat (3) @(posedge clk_sys_i);
    apb(1'b1, A_CTL, 32'h80);
    rtc <= 1'b0;
    rchk(A_VAL, 32'd10);
    apb(1'b1, A_CTL, 32'h40);
    apb(1'b1, A_VAL, 32'hfd);
    apb(1'b1, A_PIN, 32'h3);
    apb(1'b1, A_IRQ, 32'h4);
    apb(1'b1, A_CTL, 32'h50);
    m_cnt = 'hfd;
    m_pre = 'hfd;
    pulse(8'd5, 8'd2);
    m_ticks(5);
    rchk(A_VAL, m_cnt);
    rchk(A_IRQ, 32'h24);
    chk({irq, pin_oe, pin_o}, {2'b11, 1'(m_ovf)});
    chk(n_wake, m_ovf);
    apb(1'b1, A_VAL, 32'h10);
    m_pre = 'h10;
    rchk(A_VAL, m_cnt);
    pulse(8'd1, 8'd3);
    m_ticks(1);
    rchk(A_VAL, m_cnt);
    chk({pin_o, 31'(n_wake)}, {1'(m_ovf), 31'(m_ovf)});
    apb(1'b1, A_IRQ, 32'h20);
    chk(irq, 1'b0);
    rchk(A_IRQ, 32'h20);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, A_CTL, 32'h50 | (e << 3));
      idle <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      m_ticks(1 - e);
      rchk(A_VAL, m_cnt);
      idle <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      m_ticks(e);
      rchk(A_VAL, m_cnt);
    end
    tone_opt <= 1'b0;
    apb(1'b1, A_PIN, 32'h3);
    chk(pin_o, 1'b1);
    tone_opt <= 1'b1;
    @(posedge clk_sys_i);
    chk(pin_o, 32'(m_ovf % 2));
    apb(1'b1, A_PIN, 32'h2);
    chk(pin_o, 1'b0);
    apb(1'b1, A_CTL, 32'h10);
    pulse(8'd3, 8'd2);
    rchk(A_VAL, m_cnt);
    apb(1'b1, A_CTL, 32'h40);
    pulse(8'd2, 8'd2);
    rchk(A_VAL, m_cnt);
    apb(1'b1, A_CTL, 32'hc0);
    apb(1'b1, A_VAL, 32'h0);
    apb(1'b1, A_CTL, 32'hd0);
    pulse(8'd1, 8'd20);
    rchk(A_CTL, 32'hc0);
    apb(1'b0, A_VAL, 32'h0);
    v = int'(rd[7:0]) - 20;
    chk(32'(v >= -2 && v <= 2), 32'h1);
    m_cnt = rd[7:0];
    pulse(8'd1, 8'd5);
    rchk(A_VAL, m_cnt);
    idle <= 1'b1;
    apb(1'b1, A_VAL, 32'h0);
    apb(1'b1, A_CTL, 32'hd0);
    repeat (20) @(posedge clk_sys_i);
    rchk(A_VAL, 32'h0);
    stop_test();
  end
endmodule : timer_event_counter_tone_out_test
